// file: core/mplt_consts.vh
// Purpose: Shared constants of the monochrome passive panel timing generator.
// Assumes: Included by the timing generator by bare name.
// Notes: Definitions only; register offsets are byte addresses on the Wishbone bus.
`ifndef MPLT_CONSTS_VH
`define MPLT_CONSTS_VH

// ****************************************************************
// Register map (byte offsets, word aligned)
// ****************************************************************
`define MPLT_OFS_CTRL 8'h00
`define MPLT_OFS_HDISP 8'h04
`define MPLT_OFS_HBLANK 8'h08
`define MPLT_OFS_VDISP 8'h0c
`define MPLT_OFS_VBLANK 8'h10
`define MPLT_OFS_STATUS 8'h14
`define MPLT_OFS_IRQ_STAT 8'h18
`define MPLT_OFS_IRQ_MASK 8'h1c

// ****************************************************************
// Control register fields
// ****************************************************************
`define MPLT_CTRL_PS_EN 0
`define MPLT_CTRL_MODE8 1
`define MPLT_CTRL_BPP16 2
`define MPLT_CTRL_DIV_LO 4
`define MPLT_CTRL_DIV_HI 5

// ****************************************************************
// Interrupt status and mask bits
// ****************************************************************
`define MPLT_IRQ_FRAME 0
`define MPLT_IRQ_PS_ENTER 1
`define MPLT_IRQ_PS_LEAVE 2

// ****************************************************************
// Reset values
// ****************************************************************
`define MPLT_RST_CTRL 6'h00
`define MPLT_RST_HDISP 7'h27
`define MPLT_RST_HBLANK 5'h03
`define MPLT_RST_VDISP 10'h0ef
`define MPLT_RST_VBLANK 6'h03
`define MPLT_RST_IRQ 3'h0

// ****************************************************************
// Panel timing in pixel clocks; power-save entry delay in lines
// ****************************************************************
`define MPLT_FIRST_RISE_8BPP 11'h011
`define MPLT_FIRST_RISE_16BPP 11'h010
`define MPLT_LP_WIDTH 11'h00b
`define MPLT_FP_HOLD 11'h00c
`define MPLT_AC_LEAD 11'h003
`define MPLT_PS_ENTER_LINES 2'h2

`endif

// file: core/mplt_pixclk_div.v
// Purpose: Pixel clock divider; emits one tick per pixel clock period.
// Assumes: Source clock is clk_i; ratio is given minus one (0 to 3 divides by 1 to 4).
// Notes: The tick is a one-cycle enable, so the panel logic stays in one clock domain.
`default_nettype none

module mplt_pixclk_div #(
    parameter W = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] ratio_m1_i,
    output wire tick_o
);

    reg [W-1:0] cnt_reg;
    reg tick_reg;

    // Counting with >= keeps a lowered ratio from stranding the counter above it.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= {W{1'b0}};
            tick_reg <= 1'b0;
        end else if (cnt_reg >= ratio_m1_i) begin
            cnt_reg <= {W{1'b0}};
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            tick_reg <= 1'b0;
        end
    end

    assign tick_o = tick_reg;

endmodule

`default_nettype wire

// file: core/mplt_timing.v
// Purpose: Timing generator for single passive monochrome 4-bit or 8-bit panels.
// Assumes: One clock clk_i at 50 MHz, synchronous active-high reset, Wishbone classic.
// Notes: All panel timing counts pixel clock ticks from the divider below.
//
// Overview of operation
// - Horizontal display period is (field + 1) times eight pixel clocks.
// - Horizontal blank period is (field + 1) times eight pixel clocks.
// - Vertical display lines are the 10-bit upper/lower value plus one.
// - Vertical blank lines are the 6-bit field plus one.
// - Frame pulse held 12 clocks after line fall; line pulse 11 clocks wide.
// - Frame pulse rises a line period minus 12 before line fall.
// - AC-bias toggles every line, 3 clocks before line fall.
// - 4-bit mode: shift period 4, data on upper nibble around falls.
// - 8-bit mode: shift period 8, data on all lines around falls.
// - First shift rise comes 17 clocks after line fall, 16 at 16 bpp.
// - First shift fall comes 2 (4-bit) or 4 (8-bit) after that rise.
// - Last shift fall precedes line rise by blank minus 26 or 24, or 25 or 23 at 16 bpp.
// - Last shift fall precedes line fall by blank minus 15 or 13, or 14 or 12 at 16 bpp.
// - Pixel clock is the source divided by one, two, three or four.
// - Power-save status sets one to two line periods after enable.
// - Power-save status clears within one frame after enable clears.
// - Control bit zero enters power save when set, leaves when cleared.
`include "mplt_consts.vh"
`default_nettype none

module mplt_timing #(
    parameter PIX_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire [PIX_W-1:0] pix_data_i,
    output wire pix_take_o,
    output wire frame_pulse_o,
    output wire line_pulse_o,
    output wire shift_clock_out_o,
    output wire [PIX_W-1:0] panel_pixel_bus_o,
    output wire ac_bias_toggle_o,
    output wire irq_o
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [5:0] ctrl_reg;
    reg [6:0] hdisp_reg;
    reg [4:0] hblank_reg;
    reg [9:0] vdisp_reg;
    reg [5:0] vblank_reg;
    reg [2:0] irq_stat_reg;
    reg [2:0] irq_mask_reg;
    reg [2:0] irq_stat_next;
    reg ack_reg;
    reg [31:0] dat_reg;
    reg irq_reg;

    // Shadow copies taken at frame end so a frame never changes shape midway.
    reg [6:0] hd_sh_reg;
    reg [4:0] hb_sh_reg;
    reg [9:0] vd_sh_reg;
    reg [5:0] vb_sh_reg;
    reg mode8_sh_reg;
    reg bpp16_sh_reg;

    // Panel-side state.
    reg [10:0] pcnt_reg;
    reg [10:0] vcnt_reg;
    reg ps_status_reg;
    reg [1:0] ps_lines_reg;
    reg fp_reg;
    reg lp_reg;
    reg sc_reg;
    reg [PIX_W-1:0] bus_reg;
    reg ac_reg;
    reg take_reg;

    wire tick;
    wire req;
    wire wr_en;
    wire rd_en;
    wire [5:0] widx;

    // Word index compare; shared by the write and read paths.
    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // Byte-lane merge of write data into a register image.
    function [15:0] merge;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            merge[7:0] = sel[0] ? dat[7:0] : old[7:0];
            merge[15:8] = sel[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    // Pixel clock derived from clk_i by the programmed ratio.
    mplt_pixclk_div #(
        .W(2)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ratio_m1_i(ctrl_reg[`MPLT_CTRL_DIV_HI:`MPLT_CTRL_DIV_LO]),
        .tick_o(tick)
    );

    // One access per request; ack in the cycle after the strobe and dropped after one.
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_en = req & wb_we_i;
    assign rd_en = req & ~wb_we_i;
    assign widx = wb_adr_i[7:2];

    // ****************************************************************
    // Panel geometry from the shadow registers
    // ****************************************************************
    wire [10:0] hd_len = {(hd_sh_reg + 8'h01), 3'b000};
    wire [10:0] hnp = {2'b00, ({1'b0, hb_sh_reg} + 6'h01), 3'b000};
    wire [10:0] line_len = hd_len + hnp;
    wire [10:0] vd_lines = {1'b0, vd_sh_reg} + 11'h001;
    wire [10:0] vnp = {5'h00, vb_sh_reg} + 11'h001;
    wire [10:0] vtot = vd_lines + vnp;
    wire line_end = (pcnt_reg == line_len - 11'h001);
    wire frame_end = line_end & (vcnt_reg == vtot - 11'h001);
    wire line_start = (pcnt_reg == 11'h000);
    wire frame_start = line_start & (vcnt_reg == 11'h000);
    wire [10:0] first_rise = bpp16_sh_reg ? `MPLT_FIRST_RISE_16BPP
                                          : `MPLT_FIRST_RISE_8BPP;
    wire [10:0] phase = pcnt_reg - first_rise;
    wire shift_win = (vcnt_reg < vd_lines) & (pcnt_reg >= first_rise)
                     & (pcnt_reg < first_rise + hd_len);
    // High for the first half of each shift period, so each fall is mid-period.
    wire shift_high = mode8_sh_reg ? ~phase[2] : ~phase[1];
    wire shift_load = mode8_sh_reg ? (phase[2:0] == 3'h0) : (phase[1:0] == 2'h0);
    wire ps_set = tick & line_start & ctrl_reg[`MPLT_CTRL_PS_EN] & ~ps_status_reg
                  & (ps_lines_reg == `MPLT_PS_ENTER_LINES - 2'h1);
    wire ps_clr = tick & frame_start & ~ctrl_reg[`MPLT_CTRL_PS_EN] & ps_status_reg;

    // ****************************************************************
    // Wishbone writes
    // ****************************************************************
    // Byte-lane images of each writable register; only the field bits are kept.
    wire [15:0] wr_ctrl = merge({10'h000, ctrl_reg}, wb_dat_i, wb_sel_i);
    wire [15:0] wr_hdisp = merge({9'h000, hdisp_reg}, wb_dat_i, wb_sel_i);
    wire [15:0] wr_hblank = merge({11'h000, hblank_reg}, wb_dat_i, wb_sel_i);
    wire [15:0] wr_vdisp = merge({6'h00, vdisp_reg}, wb_dat_i, wb_sel_i);
    wire [15:0] wr_vblank = merge({10'h000, vblank_reg}, wb_dat_i, wb_sel_i);
    wire [15:0] wr_mask = merge({13'h0000, irq_mask_reg}, wb_dat_i, wb_sel_i);
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `MPLT_RST_CTRL;
            hdisp_reg <= `MPLT_RST_HDISP;
            hblank_reg <= `MPLT_RST_HBLANK;
            vdisp_reg <= `MPLT_RST_VDISP;
            vblank_reg <= `MPLT_RST_VBLANK;
            irq_mask_reg <= `MPLT_RST_IRQ;
        end else if (wr_en) begin
            if (hit(wb_adr_i, `MPLT_OFS_CTRL)) ctrl_reg <= wr_ctrl[5:0];
            if (hit(wb_adr_i, `MPLT_OFS_HDISP)) hdisp_reg <= wr_hdisp[6:0];
            if (hit(wb_adr_i, `MPLT_OFS_HBLANK)) hblank_reg <= wr_hblank[4:0];
            if (hit(wb_adr_i, `MPLT_OFS_VDISP)) vdisp_reg <= wr_vdisp[9:0];
            if (hit(wb_adr_i, `MPLT_OFS_VBLANK)) vblank_reg <= wr_vblank[5:0];
            if (hit(wb_adr_i, `MPLT_OFS_IRQ_MASK)) irq_mask_reg <= wr_mask[2:0];
        end
    end

    // ****************************************************************
    // Wishbone reads and acknowledge
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (rd_en) begin
                // Unmapped words read as zero and are still acknowledged.
                case ({2'b00, widx})
                    `MPLT_OFS_CTRL >> 2: dat_reg <= {26'h0, ctrl_reg};
                    `MPLT_OFS_HDISP >> 2: dat_reg <= {25'h0, hdisp_reg};
                    `MPLT_OFS_HBLANK >> 2: dat_reg <= {27'h0, hblank_reg};
                    `MPLT_OFS_VDISP >> 2: dat_reg <= {22'h0, vdisp_reg};
                    `MPLT_OFS_VBLANK >> 2: dat_reg <= {26'h0, vblank_reg};
                    `MPLT_OFS_STATUS >> 2: dat_reg <= {31'h0, ps_status_reg};
                    `MPLT_OFS_IRQ_STAT >> 2: dat_reg <= {29'h0, irq_stat_reg};
                    `MPLT_OFS_IRQ_MASK >> 2: dat_reg <= {29'h0, irq_mask_reg};
                    default: dat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Interrupt status: read clears, a new event in the same cycle wins
    // ****************************************************************
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (rd_en && hit(wb_adr_i, `MPLT_OFS_IRQ_STAT)) begin
            irq_stat_next = 3'h0;
        end
        if (tick && frame_start) begin
            irq_stat_next[`MPLT_IRQ_FRAME] = 1'b1;
        end
        if (ps_set) begin
            irq_stat_next[`MPLT_IRQ_PS_ENTER] = 1'b1;
        end
        if (ps_clr) begin
            irq_stat_next[`MPLT_IRQ_PS_LEAVE] = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= `MPLT_RST_IRQ;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ****************************************************************
    // Line and frame counters, and shadow capture at frame end
    // ****************************************************************
    // Position zero of a line is the line pulse falling edge.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pcnt_reg <= 11'h000;
            vcnt_reg <= 11'h000;
            hd_sh_reg <= `MPLT_RST_HDISP;
            hb_sh_reg <= `MPLT_RST_HBLANK;
            vd_sh_reg <= `MPLT_RST_VDISP;
            vb_sh_reg <= `MPLT_RST_VBLANK;
            mode8_sh_reg <= 1'b0;
            bpp16_sh_reg <= 1'b0;
        end else if (tick) begin
            if (frame_end) begin
                pcnt_reg <= 11'h000;
                vcnt_reg <= 11'h000;
                hd_sh_reg <= hdisp_reg;
                hb_sh_reg <= hblank_reg;
                vd_sh_reg <= vdisp_reg;
                vb_sh_reg <= vblank_reg;
                mode8_sh_reg <= ctrl_reg[`MPLT_CTRL_MODE8];
                bpp16_sh_reg <= ctrl_reg[`MPLT_CTRL_BPP16];
            end else if (line_end) begin
                pcnt_reg <= 11'h000;
                vcnt_reg <= vcnt_reg + 11'h001;
            end else begin
                pcnt_reg <= pcnt_reg + 11'h001;
            end
        end
    end

    // ****************************************************************
    // Power save handshake
    // ****************************************************************
    // Counting line starts after the enable bounds entry between one and two lines.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ps_status_reg <= 1'b0;
            ps_lines_reg <= 2'h0;
        end else begin
            if (!ctrl_reg[`MPLT_CTRL_PS_EN] || ps_status_reg) begin
                ps_lines_reg <= 2'h0;
            end else if (tick && line_start) begin
                ps_lines_reg <= ps_lines_reg + 2'h1;
            end
            if (ps_set) begin
                ps_status_reg <= 1'b1;
            end else if (ps_clr) begin
                ps_status_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Panel outputs, all registered on the pixel tick
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            fp_reg <= 1'b0;
            lp_reg <= 1'b0;
            sc_reg <= 1'b0;
            bus_reg <= {PIX_W{1'b0}};
            ac_reg <= 1'b0;
            take_reg <= 1'b0;
        end else begin
            take_reg <= 1'b0;
            if (tick) begin
                if (ps_status_reg || ps_set) begin
                    // Frame, line, shift and data outputs idle while power save is in force.
                    fp_reg <= 1'b0;
                    lp_reg <= 1'b0;
                    sc_reg <= 1'b0;
                    bus_reg <= {PIX_W{1'b0}};
                end else begin
                    // Rises at 12 in the last line, falls at 12 of the first.
                    fp_reg <= ((vcnt_reg == vtot - 11'h001) & (pcnt_reg >= `MPLT_FP_HOLD))
                              | ((vcnt_reg == 11'h000) & (pcnt_reg < `MPLT_FP_HOLD));
                    // High over the last eleven clocks of each line.
                    lp_reg <= (pcnt_reg >= line_len - `MPLT_LP_WIDTH);
                    sc_reg <= shift_win & shift_high;
                    if (shift_win && shift_load) begin
                        // Data changes with the rise, so it brackets the fall evenly.
                        bus_reg <= mode8_sh_reg ? pix_data_i
                                   : {pix_data_i[3:0], 4'h0};
                        take_reg <= 1'b1;
                    end else if (!shift_win) begin
                        bus_reg <= {PIX_W{1'b0}};
                    end
                end
                // Toggled every line, three clocks ahead of the line fall.
                if (pcnt_reg == line_len - `MPLT_AC_LEAD) begin
                    ac_reg <= ~ac_reg;
                end
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign pix_take_o = take_reg;
    assign frame_pulse_o = fp_reg;
    assign line_pulse_o = lp_reg;
    assign shift_clock_out_o = sc_reg;
    assign panel_pixel_bus_o = bus_reg;
    assign ac_bias_toggle_o = ac_reg;

endmodule

`default_nettype wire

// file: core/mplt_timing_unused_none.v
`default_nettype none
`default_nettype wire

// file: test/mplt_panel_model.sv
// Purpose: Behavioural passive panel that measures the timing it receives.
// Assumes: Sampled on clk_i; all counts are in clk_i cycles.
// Notes: The panel is a pure sink, so it never stalls the generator.
`default_nettype none

module mplt_panel_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic frame_i,
    input wire logic line_i,
    input wire logic shift_i,
    input wire logic [7:0] bus_i,
    output logic [15:0] line_clks_o,
    output logic [15:0] lines_o,
    output logic [15:0] shifts_o,
    output logic [15:0] rise_dly_o,
    output logic [15:0] fall_dly_o,
    output logic [7:0] word0_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pl, ps, pf;
    logic [15:0] clk_n, line_n, sh_n;

    // ****************************************************************
    // Edge detection and measurement
    // ****************************************************************
    // Clock and shift counters restart at each line fall, the panel's own line reference.
    always @(posedge clk_i) begin
        pl <= line_i;
        ps <= shift_i;
        pf <= frame_i;
        if (rst_i) begin
            clk_n <= 16'h0;
            line_n <= 16'h0;
            sh_n <= 16'h0;
        end else begin
            clk_n <= clk_n + 16'h1;
            if (pl && !line_i) begin
                line_clks_o <= clk_n;
                clk_n <= 16'h1;
                line_n <= line_n + 16'h1;
                sh_n <= 16'h0;
                // Blank lines carry no shifts, so keep the last display count.
                if (sh_n != 16'h0) shifts_o <= sh_n;
            end
            if (!ps && shift_i && sh_n == 16'h0) rise_dly_o <= clk_n;
            if (ps && !shift_i) begin
                sh_n <= sh_n + 16'h1;
                if (sh_n == 16'h0) begin
                    word0_o <= bus_i;
                    fall_dly_o <= clk_n;
                end
            end
            if (!pf && frame_i) begin
                lines_o <= line_n;
                line_n <= 16'h0;
            end
        end
    end
endmodule

`default_nettype wire

// file: test/mplt_timing_checker.sv
// Purpose: Port assertions for the passive panel timing generator.
// Assumes: One clock clk_i, synchronous reset rst_i.
// Notes: Bounds are in clk_i cycles, so they hold at every divide ratio.
`default_nettype none

module mplt_timing_checker #(
    parameter PIX_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pix_take_o,
    input wire logic frame_pulse_o,
    input wire logic line_pulse_o,
    input wire logic shift_clock_out_o,
    input wire logic [PIX_W-1:0] panel_pixel_bus_o,
    input wire logic ac_bias_toggle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hi_cnt, since_fall;

    // ****************************************************************
    // Helper counters
    // ****************************************************************
    // Both saturate, so long power-save gaps cannot wrap them into a false fail.
    always @(posedge clk_i) begin
        if (rst_i) begin
            hi_cnt <= 8'h00;
            since_fall <= 8'hff;
        end else begin
            hi_cnt <= !line_pulse_o ? 8'h00 : (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
            if ($fell(line_pulse_o)) since_fall <= 8'h01;
            else if (since_fall != 8'hff) since_fall <= since_fall + 8'h01;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answer: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_take_pulse: assert property (pix_take_o |=> !pix_take_o)
        else $error("pixel take longer than one cycle");
    a_line_width: assert property ($fell(line_pulse_o) |-> hi_cnt >= 8'd11)
        else $error("line pulse too narrow");
    a_frame_hold: assert property ($fell(frame_pulse_o) |-> since_fall >= 8'd12)
        else $error("frame pulse hold too short");
    a_frame_rise: assert property ($rose(frame_pulse_o) |->
        !line_pulse_o && since_fall >= 8'd12)
        else $error("frame pulse rose early");
    a_ac_lead: assert property ($fell(line_pulse_o) |-> $stable(ac_bias_toggle_o) &&
        ac_bias_toggle_o == $past(ac_bias_toggle_o, 3))
        else $error("ac bias changed too close to line fall");
    a_shift_delay: assert property ($rose(shift_clock_out_o) |-> since_fall >= 8'd16)
        else $error("shift rose too soon after line fall");
    a_shift_high: assert property ($rose(shift_clock_out_o) |-> shift_clock_out_o [*2])
        else $error("shift high phase too short");
    a_data_hold: assert property ($fell(shift_clock_out_o) |->
        $stable(panel_pixel_bus_o) ##1 $stable(panel_pixel_bus_o))
        else $error("pixel bus moved around shift fall");
endmodule

bind mplt_timing mplt_timing_checker #(.PIX_W(PIX_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pix_take_o(pix_take_o),
    .frame_pulse_o(frame_pulse_o), .line_pulse_o(line_pulse_o),
    .shift_clock_out_o(shift_clock_out_o), .panel_pixel_bus_o(panel_pixel_bus_o),
    .ac_bias_toggle_o(ac_bias_toggle_o));

`default_nettype wire

// file: test/mplt_timing_tb.sv
// Purpose: Self-checking bench for the passive panel timing generator.
// Assumes: 50 MHz clk_i; the first frame runs at the long reset geometry.
// Notes: Geometry is shadowed, so each setup is judged a few frames later.
`default_nettype none

module mplt_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pac, quiet;
    logic [7:0] wb_adr_i, pix_data_i, px, panel_pixel_bus_o, word0;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_ack_o, pix_take_o, frame_pulse_o, line_pulse_o, shift_clock_out_o;
    logic ac_bias_toggle_o, irq_o;
    logic [15:0] line_clks, lines, shifts, rise_dly, fall_dly;
    int n_fail, total_checks, n, len, ctrl, tg, f;
    // Columns: 8-bit mode, 16 bpp, divide-1, hdisp, hblank, vdisp, vblank.
    int cfg [4][7] = '{'{0,0,0,1,3,1,0}, '{1,1,1,2,1,2,1}, '{0,1,2,1,2,1,2}, '{1,0,3,1,3,3,0}};
    logic [7:0] radr [6] = '{8'h20, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rval [6] = '{32'h0, 32'h0, 32'h27, 32'h3, 32'hef, 32'h3};

    mplt_timing #(.PIX_W(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pix_data_i(pix_data_i), .pix_take_o(pix_take_o), .frame_pulse_o(frame_pulse_o),
        .line_pulse_o(line_pulse_o), .shift_clock_out_o(shift_clock_out_o),
        .panel_pixel_bus_o(panel_pixel_bus_o), .ac_bias_toggle_o(ac_bias_toggle_o),
        .irq_o(irq_o));
    mplt_panel_model i_panel (.clk_i(clk_i), .rst_i(rst_i), .frame_i(frame_pulse_o),
        .line_i(line_pulse_o), .shift_i(shift_clock_out_o), .bus_i(panel_pixel_bus_o),
        .line_clks_o(line_clks), .lines_o(lines), .shifts_o(shifts), .rise_dly_o(rise_dly),
        .fall_dly_o(fall_dly), .word0_o(word0));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Classic single cycle; request held until ack is sampled, then dropped.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            print_verdict();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Counts edges until the interrupt line is high; a spent bound ends the run.
    task wait_irq(input int lim);
        n = 0;
        while (irq_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) begin
            n_fail++;
            print_verdict();
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 40'h0};
        wb_sel_i = 4'hf;
        pix_data_i = 8'h00;
        n_fail = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // The unmapped write must vanish; the table then reads it back as zero.
        wb(1'b1, 8'h20, 32'hff);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, radr[i], 32'h0);
            chk("reset value", rval[i], rd);
        end
        wb(1'b1, 8'h1c, 32'h1);
        for (int c = 0; c < 4; c++) begin
            ctrl = (cfg[c][2] << 4) | (cfg[c][1] << 2) | (cfg[c][0] << 1);
            for (int r = 0; r < 4; r++) wb(1'b1, 8'h04 + 8'(4 * r), 32'(cfg[c][r + 3]));
            wb(1'b1, 8'h00, 32'(ctrl));
            px = 8'h5a + 8'(c);
            pix_data_i <= px;
            repeat (4) begin
                wait_irq(100000);
                wb(1'b0, 8'h18, 32'h0);
                repeat (2) @(posedge clk_i);
                chk("irq after clear", 32'h0, {31'h0, irq_o});
            end
            f = cfg[c][1] ? 16 : 17;
            len = ((cfg[c][3] + 1) * 8 + (cfg[c][4] + 1) * 8) * (cfg[c][2] + 1);
            chk("line clocks", len, line_clks);
            chk("lines per frame", cfg[c][5] + cfg[c][6] + 2, lines);
            chk("shifts per line", (cfg[c][3] + 1) * (cfg[c][0] ? 1 : 2), shifts);
            chk("first rise", f * (cfg[c][2] + 1), rise_dly);
            chk("first fall", (f + (cfg[c][0] ? 4 : 2)) * (cfg[c][2] + 1), fall_dly);
            chk("first word", cfg[c][0] ? px : {px[3:0], 4'h0}, word0);
        end
        // Power save entry and exit with the last setup still running.
        wb(1'b1, 8'h1c, 32'h6);
        wb(1'b1, 8'h00, 32'(ctrl | 1));
        wait_irq(3 * len);
        chk("enter delay in range", 32'h1, 32'(n >= len && n <= 2 * len + 2));
        wb(1'b0, 8'h14, 32'h0);
        chk("power save status", 32'h1, rd & 32'h1);
        wb(1'b0, 8'h18, 32'h0);
        chk("enter event", 32'h2, rd & 32'h2);
        quiet = 1'b1;
        tg = 0;
        pac = ac_bias_toggle_o;
        repeat (len) begin
            @(posedge clk_i);
            if ({frame_pulse_o, line_pulse_o, shift_clock_out_o, panel_pixel_bus_o} !== 11'h0)
                quiet = 1'b0;
            if (ac_bias_toggle_o !== pac) tg++;
            pac = ac_bias_toggle_o;
        end
        chk("outputs idle", 32'h1, {31'h0, quiet});
        chk("ac toggles per line", 32'h1, tg);
        wb(1'b1, 8'h00, 32'(ctrl));
        wait_irq(5 * len + 3);
        chk("leave within frame", 32'h1, 32'(n <= 5 * len + 2));
        wb(1'b0, 8'h14, 32'h0);
        chk("status cleared", 32'h0, rd & 32'h1);
        n = 0;
        while (line_pulse_o !== 1'b1 && n < len) begin
            @(posedge clk_i);
            n++;
        end
        chk("outputs resume", 32'h1, 32'(n < len));
        print_verdict();
    end
endmodule

`default_nettype wire
